// >>> logic/ccc_channel.sv
// one compare/capture channel with its own small 16-bit counter and apb registers
// assumes an apb master on pclk; capture pin and partner match come from outside
`timescale 1ns/10ps
module ccc_channel #(
    parameter int CNT_W = 16
) (
    // apb clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // capture pin and pair match
    input  wire logic             capture_input_pin,
    input  wire logic             pair_match_in,
    // channel outputs
    output logic                  waveform_output,
    output logic                  compare_match,
    output logic                  capture_event
);
    // field positions and masks assume a 16-bit counter
    if (CNT_W != 16)
    begin : g_width_check
        $error("ccc_channel supports only a 16-bit counter");
    end

    logic [15:0]          ctl_q;
    logic [15:0]          ccr_q;
    logic [15:0]          buf_q;
    logic [15:0]          max_q;
    logic [15:0]          cnt_q;
    logic [15:0]          cnt_d;
    logic                 run_q;
    ccc_pkg::ccc_cnt_mode_t cmode_q;
    logic                 up_q;
    logic                 pin_s;
    logic                 pin_prev_q;
    logic                 trig_pend_q;
    logic                 wave_q;
    logic                 rd_ready_q;

    // apb decode
    logic       setup_phase;
    logic       wr_done;
    logic       wr_ctl;
    logic       wr_data;
    logic       wr_timer;
    logic       wr_max;
    logic [15:0] ctl_new;

    assign setup_phase = psel && !penable;
    assign wr_done     = psel && penable && rd_ready_q && pwrite;
    assign wr_ctl      = wr_done && (paddr == ccc_pkg::CTL_OFS);
    assign wr_data     = wr_done && (paddr == ccc_pkg::DATA_OFS);
    assign wr_timer    = wr_done && (paddr == ccc_pkg::TIMER_OFS);
    assign wr_max      = wr_done && (paddr == ccc_pkg::MAX_OFS);
    assign ctl_new     = pwdata[15:0] & ccc_pkg::CTL_WMASK;

    // control fields
    logic        capt_mode;
    logic        sync_sel;
    logic [2:0]  load_sel;
    logic [1:0]  src_sel;
    logic [1:0]  edge_sel;
    logic        dual_sel;
    logic        sw_level;
    logic [2:0]  omode_sel;
    logic        inv_sel;

    assign capt_mode = ctl_q[ccc_pkg::CAPT_BIT];
    assign sync_sel  = ctl_q[ccc_pkg::SYNC_BIT];
    assign load_sel  = ctl_q[ccc_pkg::LOAD_LSB +: 3];
    assign src_sel   = ctl_q[ccc_pkg::SRC_LSB +: 2];
    assign edge_sel  = ctl_q[ccc_pkg::EDGE_LSB +: 2];
    assign dual_sel  = ctl_q[ccc_pkg::DUAL_BIT];
    assign sw_level  = ctl_q[ccc_pkg::LEVEL_BIT];
    assign omode_sel = ctl_q[ccc_pkg::OMODE_LSB +: 3];
    assign inv_sel   = ctl_q[ccc_pkg::INV_BIT];

    ccc_sync2 u_pin_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   (capture_input_pin),
        .dout  (pin_s)
    );

    // counter: next value, limits and match against the active buffer
    logic at_max;
    logic at_zero;
    logic buf_eq;
    logic clear_on_match;

    assign at_max  = (cnt_q == max_q);
    assign at_zero = (cnt_q == 16'h_0000);
    assign buf_eq  = run_q && (cnt_q == buf_q);
    assign clear_on_match = !capt_mode && buf_eq && (load_sel == ccc_pkg::LOAD_CLEAR);

    always_comb
    begin
        cnt_d = cnt_q;
        if (run_q)
        begin
            if (clear_on_match)
            begin
                if (cmode_q == ccc_pkg::CNT_DOWN)
                begin
                    cnt_d = max_q;
                end
                else
                begin
                    cnt_d = 16'h_0000;
                end
            end
            else if (up_q)
            begin
                cnt_d = at_max ? 16'h_0000 : cnt_q + 16'h_0001;
                if (cmode_q == ccc_pkg::CNT_UPDOWN && at_max)
                begin
                    cnt_d = cnt_q - 16'h_0001;
                end
            end
            else
            begin
                cnt_d = at_zero ? max_q : cnt_q - 16'h_0001;
                if (cmode_q == ccc_pkg::CNT_UPDOWN && at_zero)
                begin
                    cnt_d = cnt_q + 16'h_0001;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 16'h_0000;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // direction; up/down mode turns at the limits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            up_q <= 1'b1;
        end
        else if (wr_timer)
        begin
            up_q <= (pwdata[ccc_pkg::CMOD_LSB +: 2] != ccc_pkg::CNT_DOWN);
        end
        else if (run_q && cmode_q == ccc_pkg::CNT_UPDOWN)
        begin
            if (up_q && (at_max || clear_on_match))
            begin
                up_q <= clear_on_match;
            end
            else if (!up_q && at_zero)
            begin
                up_q <= 1'b1;
            end
        end
    end

    // load events for the compare buffer; limit loads are judged on the counter's next value
    logic nxt_max;
    logic nxt_zero;
    logic load_evt;

    assign nxt_max  = run_q && (cnt_d == max_q);
    assign nxt_zero = run_q && (cnt_d == 16'h_0000);

    always_comb
    begin
        load_evt = 1'b0;
        case (load_sel)
            ccc_pkg::LOAD_NOW:   load_evt = 1'b1;
            ccc_pkg::LOAD_LIMIT:
            begin
                case (cmode_q)
                    ccc_pkg::CNT_UP:   load_evt = nxt_max;
                    ccc_pkg::CNT_DOWN: load_evt = nxt_zero;
                    default:           load_evt = nxt_max || nxt_zero;
                endcase
            end
            ccc_pkg::LOAD_MATCH: load_evt = buf_eq;
            ccc_pkg::LOAD_WRAP:
            begin
                case (cmode_q)
                    ccc_pkg::CNT_UP:   load_evt = run_q && up_q && at_max;
                    ccc_pkg::CNT_DOWN: load_evt = run_q && at_zero;
                    default:           load_evt = buf_eq || (nxt_zero && !at_zero);
                endcase
            end
            ccc_pkg::LOAD_CLEAR: load_evt = buf_eq;
            // reserved codes never load; software keeps away from them
            default:             load_evt = 1'b0;
        endcase
    end

    // buffer only moves in comparator mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_q <= 16'h_0000;
        end
        else if (!capt_mode && load_evt)
        begin
            buf_q <= ccr_q;
        end
    end

    // capture triggers
    logic pin_rise;
    logic pin_fall;
    logic pin_trig;
    logic sw_trig;
    logic [1:0] src_new;
    logic trig_now;
    logic capture_fire;

    assign pin_rise = pin_s && !pin_prev_q;
    assign pin_fall = !pin_s && pin_prev_q;
    assign src_new  = ctl_new[ccc_pkg::SRC_LSB +: 2];

    always_comb
    begin
        pin_trig = 1'b0;
        sw_trig  = 1'b0;
        case (edge_sel)
            ccc_pkg::EDGE_RISE:
            begin
                pin_trig = pin_rise;
                sw_trig  = src_sel == ccc_pkg::SRC_SW_LOW && src_new == ccc_pkg::SRC_SW_HI;
            end
            ccc_pkg::EDGE_FALL:
            begin
                pin_trig = pin_fall;
                sw_trig  = src_sel == ccc_pkg::SRC_SW_HI && src_new == ccc_pkg::SRC_SW_LOW;
            end
            ccc_pkg::EDGE_BOTH:
            begin
                pin_trig = pin_rise || pin_fall;
                sw_trig  = src_sel[1] && src_new[1] && (src_sel[0] != src_new[0]);
            end
            default:
            begin
                pin_trig = 1'b0;
                sw_trig  = 1'b0;
            end
        endcase
    end

    // pin source is code 0; codes 2 and 3 trigger only through writes of the field
    assign trig_now = capt_mode && ((src_sel == ccc_pkg::SRC_PIN && pin_trig) ||
                      (wr_ctl && sw_trig));
    // synchronous capture waits one edge so the copy lines up with a counter step
    assign capture_fire = sync_sel ? trig_pend_q : trig_now;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_q  <= 1'b0;
            trig_pend_q <= 1'b0;
        end
        else
        begin
            pin_prev_q  <= pin_s;
            trig_pend_q <= trig_now && sync_sel;
        end
    end

    // data register: software value, or counter copy on capture; capture wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ccr_q <= 16'h_0000;
        end
        else if (capture_fire)
        begin
            ccr_q <= cnt_q;
        end
        else if (wr_data)
        begin
            ccr_q <= pwdata[15:0];
        end
    end

    // waveform generation
    logic rise_src;
    logic limit_src;
    logic set_evt;
    logic clr_evt;
    logic tog_evt;
    logic own_match;

    assign own_match = !capt_mode && buf_eq;
    assign limit_src = (cmode_q == ccc_pkg::CNT_DOWN) ? at_zero && run_q : at_max && run_q;
    assign rise_src  = dual_sel ? pair_match_in : limit_src;

    always_comb
    begin
        set_evt = 1'b0;
        clr_evt = 1'b0;
        tog_evt = 1'b0;
        case (omode_sel)
            ccc_pkg::OUT_TOG_RESET:
            begin
                tog_evt = own_match;
                clr_evt = rise_src;
            end
            ccc_pkg::OUT_SET_RESET:
            begin
                set_evt = own_match;
                clr_evt = rise_src;
            end
            ccc_pkg::OUT_TOGGLE: tog_evt = own_match || (dual_sel && pair_match_in);
            ccc_pkg::OUT_RESET:  clr_evt = own_match || (dual_sel && pair_match_in);
            ccc_pkg::OUT_TOG_SET:
            begin
                tog_evt = own_match;
                set_evt = rise_src;
            end
            ccc_pkg::OUT_RESET_SET:
            begin
                clr_evt = own_match;
                set_evt = rise_src;
            end
            default:
            begin
                set_evt = 1'b0;
            end
        endcase
    end

    // in capture mode the compare fields are ignored and the output holds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wave_q <= 1'b0;
        end
        else if (!capt_mode)
        begin
            if (omode_sel == ccc_pkg::OUT_SW)
            begin
                wave_q <= sw_level;
            end
            else if (set_evt)
            begin
                wave_q <= 1'b1;
            end
            else if (clr_evt)
            begin
                wave_q <= 1'b0;
            end
            else if (tog_evt)
            begin
                wave_q <= !wave_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            waveform_output <= 1'b0;
            compare_match   <= 1'b0;
            capture_event   <= 1'b0;
        end
        else
        begin
            waveform_output <= wave_q ^ inv_sel;
            compare_match   <= own_match;
            capture_event   <= capture_fire;
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q   <= ccc_pkg::CTL_RESET;
            max_q   <= ccc_pkg::MAX_RESET;
            run_q   <= 1'b0;
            cmode_q <= ccc_pkg::CNT_UP;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctl_q <= ctl_new;
            end
            if (wr_max)
            begin
                max_q <= pwdata[15:0];
            end
            if (wr_timer)
            begin
                run_q   <= pwdata[ccc_pkg::RUN_BIT];
                cmode_q <= ccc_pkg::ccc_cnt_mode_t'(pwdata[ccc_pkg::CMOD_LSB +: 2]);
            end
        end
    end

    // apb answer: read data sampled in setup, ready in the first access cycle
    logic [31:0] rd_d;
    logic        err_d;

    always_comb
    begin
        rd_d  = 32'h_0000_0000;
        err_d = 1'b0;
        if (paddr == ccc_pkg::CTL_OFS)
        begin
            rd_d[15:0] = ctl_q;
        end
        else if (paddr == ccc_pkg::DATA_OFS)
        begin
            rd_d[15:0] = ccr_q;
        end
        else if (paddr == ccc_pkg::TIMER_OFS)
        begin
            rd_d[ccc_pkg::RUN_BIT]       = run_q;
            rd_d[ccc_pkg::CMOD_LSB +: 2] = cmode_q;
        end
        else if (paddr == ccc_pkg::MAX_OFS)
        begin
            rd_d[15:0] = max_q;
        end
        else if (paddr == ccc_pkg::STATUS_OFS)
        begin
            rd_d[15:0]                 = cnt_q;
            rd_d[ccc_pkg::ST_UP_BIT]   = up_q;
            rd_d[ccc_pkg::ST_WAVE_BIT] = wave_q;
            rd_d[ccc_pkg::ST_PIN_BIT]  = pin_s;
        end
        else if (paddr == ccc_pkg::BUF_OFS)
        begin
            rd_d[15:0] = buf_q;
        end
        else
        begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_ready_q <= 1'b0;
            prdata     <= 32'h_0000_0000;
            pslverr    <= 1'b0;
        end
        else
        begin
            rd_ready_q <= setup_phase;
            if (setup_phase)
            begin
                prdata  <= pwrite ? 32'h_0000_0000 : rd_d;
                pslverr <= err_d;
            end
        end
    end

    assign pready = rd_ready_q;
endmodule

// >>> logic/ccc_pkg.sv
// constants, field layout and encodings of one compare/capture channel
// assumes a 16-bit timer counter and an apb slave with 32-bit data
// Notes on behaviour
// - sync select 1 means synchronous capture, 0 means asynchronous capture
// - sync, trigger source and trigger edge fields do nothing in comparator mode
// - load timing, dual match and software level do nothing in capture mode
// - load timing 0: buffer takes the written value at the next clock edge
// - load timing 1: load at max counting up, zero down, both up/down
// - load timing 2: load when counter equals the previously loaded value
// - load timing 3: load on wrap to zero up, to max down; up/down: match or zero
// - load timing 4 up or up/down: load on match and clear counter to zero
// - load timing 4 down: load on match and reload counter with max
// - source 0 is the capture pin; 2 and 3 are software levels low and high
// - on the selected trigger edge copy the counter into the channel data register
// - trigger edge 0 disables capture from every source
// - edge 1: rising pin edge, or software source changed from 2 to 3
// - edge 2: falling pin edge, or software source changed from 3 to 2
// - edge 3: either pin edge, or any software change between 2 and 3
// - dual match 1: output built from both match signals of the comparator pair
// - dual match 0: output built from own match and counter max or zero
// - output mode 0: output follows the software level bit
package ccc_pkg;
    // byte offsets of the apb registers
    localparam logic [7:0] CTL_OFS    = 8'h00;
    localparam logic [7:0] DATA_OFS   = 8'h04;
    localparam logic [7:0] TIMER_OFS  = 8'h08;
    localparam logic [7:0] MAX_OFS    = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] BUF_OFS    = 8'h14;
    // control register fields
    localparam int SYNC_BIT  = 15;
    localparam int LOAD_LSB  = 12;
    localparam int SRC_LSB   = 10;
    localparam int EDGE_LSB  = 8;
    localparam int DUAL_BIT  = 6;
    localparam int LEVEL_BIT = 5;
    localparam int OMODE_LSB = 2;
    localparam int INV_BIT   = 1;
    localparam int CAPT_BIT  = 0;
    localparam logic [15:0] CTL_WMASK = 16'h_FF7F;
    localparam logic [15:0] CTL_RESET = 16'h_0000;
    // timer register fields
    localparam int RUN_BIT  = 0;
    localparam int CMOD_LSB = 1;
    localparam logic [15:0] MAX_RESET = 16'h_FFFF;
    // status register fields
    localparam int ST_UP_BIT   = 16;
    localparam int ST_WAVE_BIT = 17;
    localparam int ST_PIN_BIT  = 18;
    // trigger source and edge codes
    localparam logic [1:0] SRC_PIN    = 2'h_0;
    localparam logic [1:0] SRC_SW_LOW = 2'h_2;
    localparam logic [1:0] SRC_SW_HI  = 2'h_3;
    localparam logic [1:0] EDGE_OFF   = 2'h_0;
    localparam logic [1:0] EDGE_RISE  = 2'h_1;
    localparam logic [1:0] EDGE_FALL  = 2'h_2;
    localparam logic [1:0] EDGE_BOTH  = 2'h_3;
    typedef enum logic [1:0] {
        CNT_UP     = 2'b00,
        CNT_DOWN   = 2'b01,
        CNT_UPDOWN = 2'b10
    } ccc_cnt_mode_t;
    typedef enum logic [2:0] {
        LOAD_NOW   = 3'b000,
        LOAD_LIMIT = 3'b001,
        LOAD_MATCH = 3'b010,
        LOAD_WRAP  = 3'b011,
        LOAD_CLEAR = 3'b100
    } ccc_load_t;
    typedef enum logic [2:0] {
        OUT_SW        = 3'b000,
        OUT_TOG_RESET = 3'b010,
        OUT_SET_RESET = 3'b011,
        OUT_TOGGLE    = 3'b100,
        OUT_RESET     = 3'b101,
        OUT_TOG_SET   = 3'b110,
        OUT_RESET_SET = 3'b111
    } ccc_out_mode_t;
endpackage

// >>> logic/ccc_sync2.sv
// two flip-flop synchroniser for one level from outside the clock domain
// assumes the input may change at any time relative to clk
`timescale 1ns/10ps
module ccc_sync2 (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    // meta_q is read only by dout
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// >>> sim/ccc_channel_chk.sv
// checker for one compare/capture channel, watching only its ports
// assumes the apb master and pin partner of the channel bench
`timescale 1ns/10ps
module ccc_channel_chk #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and pulses
    input wire logic        capture_input_pin,
    input wire logic        pair_match_in,
    input wire logic        waveform_output,
    input wire logic        compare_match,
    input wire logic        capture_event
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("ready without select");
    a_unmapped_err: assert property (psel && !penable && paddr > 8'h14
        |=> pslverr && prdata == 32'h_0000_0000)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (psel && !penable && paddr <= 8'h14
        && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    a_write_reads_zero: assert property (psel && !penable && pwrite
        |=> prdata == 32'h_0000_0000)
        else $error("read data not zero on write");
    // one-cycle pulses: the counter moves on every running cycle
    a_match_pulse: assert property (compare_match |=> !compare_match)
        else $error("match longer than one cycle");
    a_event_pulse: assert property (capture_event |=> !capture_event)
        else $error("capture event longer than one cycle");
    a_mode_excl: assert property (!(compare_match && capture_event))
        else $error("match and capture together");
    a_reset_quiet: assert property ($rose(presetn) |-> !waveform_output
        && !compare_match && !capture_event && !pready)
        else $error("output active after reset");
endmodule
bind ccc_channel ccc_channel_chk #(.CNT_W(CNT_W)) ccc_channel_chk_i (.*);

// >>> sim/ccc_pin_partner.sv
// far side of the channel: drives the capture pin
// assumes the bench asks for a level and a lag in clock cycles
`timescale 1ns/10ps
module ccc_pin_partner (
    // clock
    input wire logic       pclk,
    // level asked for and its lag
    input wire logic       want,
    input wire logic [3:0] lag,
    // capture pin
    output logic           pin
);
    logic [3:0] n_q = 4'h_0;
    logic       pin_q = 1'b0;
    assign pin = pin_q;
    // pin moves on the edge; the channel's two flops absorb its lack of relation to pclk
    always @(posedge pclk)
    begin
        if (want == pin_q)
            n_q <= 4'h_0;
        else if (n_q < lag)
            n_q <= n_q + 4'h_1;
        else
            pin_q <= want;
    end
endmodule

// >>> sim/tb_compare_capture_channel_control.sv
// bench for one compare/capture channel over apb
// assumes the channel, its package, checker and pin partner
`timescale 1ns/10ps
module tb_compare_capture_channel_control;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, want, er, pm;
    logic        pready, pslverr, pin, wave, match, cev;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cnt;
    logic [3:0]  lag;
    int          fails = 0;
    int          checks = 0;
    int          ev_n = 0;
    int          ev0, n;

    ccc_channel ccc_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(pin), .pair_match_in(pm),
        .waveform_output(wave), .compare_match(match), .capture_event(cev));
    ccc_pin_partner ccc_pin_partner_i (.pclk(pclk), .want(want), .lag(lag), .pin(pin));

    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (cev === 1'b1)
            ev_n <= ev_n + 1;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 16'h_0000);
        chk(rd, exp);
    endtask
    task automatic period;
        do @(posedge pclk); while (match !== 1'b1);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (match !== 1'b1);
    endtask
    task automatic evchk(input logic [15:0] c, input int exp);
        ev0 = ev_n;
        xfer(1'b1, ccc_pkg::CTL_OFS, c);
        repeat (4) @(posedge pclk);
        chk(ev_n - ev0, exp);
    endtask
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #200_000;
        fails++;
        $display("watchdog expired");
        summarize;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, want, pm, paddr, pwdata, lag} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ccc_pkg::CTL_OFS, 32'h_0000_0000);
        rdchk(ccc_pkg::MAX_OFS, 32'h_0000_FFFF);
        xfer(1'b0, 8'h_18, 16'h_0000);
        chk({31'h_0, er}, 32'h_0000_0001);
        xfer(1'b1, ccc_pkg::CTL_OFS, 16'h_CFFF);
        rdchk(ccc_pkg::CTL_OFS, 32'h_0000_CF7F);
        $display("test registers done");
        xfer(1'b1, ccc_pkg::CTL_OFS, 16'h_0020);
        repeat (3) @(posedge pclk);
        chk({31'h_0, wave}, 32'h_0000_0001);
        xfer(1'b1, ccc_pkg::CTL_OFS, 16'h_0001);
        repeat (3) @(posedge pclk);
        chk({31'h_0, wave}, 32'h_0000_0001);
        xfer(1'b1, ccc_pkg::CTL_OFS, 16'h_0000);
        repeat (3) @(posedge pclk);
        chk({31'h_0, wave}, 32'h_0000_0000);
        $display("test software level done");
        xfer(1'b1, ccc_pkg::MAX_OFS, 16'h_000F);
        xfer(1'b1, ccc_pkg::DATA_OFS, 16'h_0007);
        rdchk(ccc_pkg::BUF_OFS, 32'h_0000_0007);
        xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0001);
        period;
        chk(n, 16);
        xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0000);
        xfer(1'b1, ccc_pkg::CTL_OFS, 16'h_2000);
        xfer(1'b1, ccc_pkg::DATA_OFS, 16'h_0003);
        rdchk(ccc_pkg::BUF_OFS, 32'h_0000_0007);
        xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0001);
        do @(posedge pclk); while (match !== 1'b1);
        rdchk(ccc_pkg::BUF_OFS, 32'h_0000_0003);
        xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0000);
        xfer(1'b1, ccc_pkg::CTL_OFS, 16'h_1000);
        xfer(1'b1, ccc_pkg::DATA_OFS, 16'h_0009);
        rdchk(ccc_pkg::BUF_OFS, 32'h_0000_0003);
        xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0001);
        repeat (20) @(posedge pclk);
        rdchk(ccc_pkg::BUF_OFS, 32'h_0000_0009);
        // the counter clear shortens the period from 16 to 6
        xfer(1'b1, ccc_pkg::CTL_OFS, 16'h_4000);
        xfer(1'b1, ccc_pkg::DATA_OFS, 16'h_0005);
        period;
        period;
        chk(n, 6);
        xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0003);
        period;
        period;
        chk(n, 11);
        xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0000);
        $display("test buffer load done");
        for (int e = 0; e < 4; e++)
        begin
            lag <= e[3:0];
            xfer(1'b1, ccc_pkg::CTL_OFS, {e[0], 5'h_00, e[1:0], 8'h_01});
            ev0 = ev_n;
            want <= 1'b1;
            repeat (12) @(posedge pclk);
            chk(ev_n - ev0, e[0]);
            ev0 = ev_n;
            want <= 1'b0;
            repeat (12) @(posedge pclk);
            chk(ev_n - ev0, e[1]);
        end
        for (int e = 0; e < 4; e++)
        begin
            evchk({6'h_02, e[1:0], 8'h_01}, 0);
            evchk({6'h_03, e[1:0], 8'h_01}, e[0]);
            evchk({6'h_02, e[1:0], 8'h_01}, e[1]);
        end
        evchk(16'h_0B00, 0);
        evchk(16'h_0F00, 0);
        xfer(1'b0, ccc_pkg::STATUS_OFS, 16'h_0000);
        cnt = rd[15:0];
        evchk(16'h_0901, 0);
        evchk(16'h_0D01, 1);
        rdchk(ccc_pkg::DATA_OFS, {16'h_0000, cnt});
        for (int s = 0; s < 2; s++)
        begin
            xfer(1'b1, ccc_pkg::CTL_OFS, {s[0], 15'h_0901});
            xfer(1'b1, ccc_pkg::CTL_OFS, {s[0], 15'h_0D01});
            @(posedge pclk);
            chk({31'h_0, cev}, {31'h_0, !s[0]});
            @(posedge pclk);
            chk({31'h_0, cev}, {31'h_0, s[0]});
        end
        $display("test capture done");
        xfer(1'b1, ccc_pkg::DATA_OFS, 16'h_0007);
        for (int d = 0; d < 2; d++)
        begin
            xfer(1'b1, ccc_pkg::CTL_OFS, {9'h_000, d[0], 6'h_0C});
            xfer(1'b1, ccc_pkg::TIMER_OFS, 16'h_0001);
            do @(posedge pclk); while (match !== 1'b1);
            repeat (4) @(posedge pclk);
            chk({31'h_0, wave}, 32'h_0000_0001);
            repeat (5) @(posedge pclk);
            chk({31'h_0, wave}, {31'h_0, d[0]});
            pm <= 1'b1;
            @(posedge pclk);
            pm <= 1'b0;
            repeat (2) @(posedge pclk);
            chk({31'h_0, wave}, 32'h_0000_0000);
        end
        $display("test output done");
        summarize;
    end
endmodule
